// ==== shared/aeqc_pkg.sv ====
// Behaviour
// - Control A bit 0 enables adaptation
// - Mode codes 0,2 fast; 1,3 full variants
// - Control A bits 7-4 cap full search
// - Electrical idle enters U1, or U3 if set
// - Offset sign bit: zero adds, one subtracts
// - Threshold code sets symmetric limits in 40 mV steps
// - Offset field adds 0..7 or -8..-1
// - Offset applies only in full adaptation
// - Fast long channel on receiver 1 uses receiver B field
// - Fast long channel on receiver 0 uses receiver A field
// - Fast short channel uses short EQ fields
package aeqc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] AEQC_ADDR_CTRL_A = 8'h1c;
    localparam logic [7:0] AEQC_ADDR_CTRL_B = 8'h1d;
    localparam logic [7:0] AEQC_ADDR_LONG_EQ = 8'h1e;
    localparam logic [7:0] AEQC_RST_CTRL_A = 8'h80;
    localparam logic [7:0] AEQC_RST_CTRL_B = 8'h10;
    localparam logic [7:0] AEQC_RST_LONG_EQ = 8'h77;
    localparam logic [7:0] AEQC_CTRL_B_MASK = 8'hbf; // Bit 6 reads zero
    localparam logic [7:0] AEQC_UNMAPPED_DATA = 8'h00;

    // ****************************************************************
    // Channel classification and EQ range
    // ****************************************************************
    localparam int AEQC_LIMIT_STEP_MV = 40;
    localparam logic [10:0] AEQC_LIMIT_STEP = 11'(AEQC_LIMIT_STEP_MV);
    localparam logic [3:0] AEQC_EQ_MAX = 4'hf;
    localparam int AEQC_NUM_RX = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        AEQC_MODE_FAST_0 = 2'b00,
        AEQC_MODE_FULL_ALL = 2'b01,
        AEQC_MODE_FAST_2 = 2'b10,
        AEQC_MODE_FULL_EQ0 = 2'b11
    } aeqc_mode_e;

    typedef struct packed {
        logic [3:0] full_search_max_eq;
        logic idle_enters_u3;
        aeqc_mode_e adapt_mode_sel;
        logic adapt_enable;
    } aeqc_ctrl_a_s;

    typedef struct packed {
        logic eq_offset_sign;
        logic reserved;
        logic [2:0] channel_class_threshold;
        logic [2:0] eq_offset_value;
    } aeqc_ctrl_b_s;

    typedef struct packed {
        logic [3:0] long_channel_eq_rx_b;
        logic [3:0] long_channel_eq_rx_a;
    } aeqc_long_eq_s;

    // Per receiver: measured DAC level (signed mV), full search result,
    // and short channel EQ setting
    typedef struct packed {
        logic signed [9:0] dac_level;
        logic [3:0] full_eq;
        logic [3:0] short_eq;
    } aeqc_rx_meas_s;

    // Settings handed to each receiver's EQ resolver
    typedef struct packed {
        logic adapt_enable;
        logic full_mode;
        logic eq_offset_sign;
        logic [2:0] eq_offset_value;
        logic [10:0] limit_mv;
    } aeqc_rx_cfg_s;

    // Address match used by both write and read decoding
    function automatic logic aeqc_hit(input logic [7:0] addr,
                                      input logic [7:0] target);
        aeqc_hit = (addr == target);
    endfunction : aeqc_hit

endpackage : aeqc_pkg

// ==== hdl/aeqc_rx_eq.sv ====
`timescale 1ns/1ps
`default_nettype none
module aeqc_rx_eq (
    input wire logic CLK,
    input wire logic RESET,
    input wire aeqc_pkg::aeqc_rx_cfg_s CFG,
    input wire aeqc_pkg::aeqc_rx_meas_s MEAS,
    input wire logic [3:0] LONG_EQ,
    output logic [3:0] EQ,
    output logic IS_SHORT
);
    import aeqc_pkg::*;

    // ****************************************************************
    // Channel classification
    // ****************************************************************
    logic [10:0] dac_ext;
    logic [10:0] dac_mag;
    logic short_ch;
    // Magnitude taken at 11 bits so the most negative level cannot wrap
    assign dac_ext = {MEAS.dac_level[9], MEAS.dac_level};
    assign dac_mag = MEAS.dac_level[9] ? 11'(-dac_ext) : dac_ext;
    assign short_ch = (dac_mag <= CFG.limit_mv);

    // ****************************************************************
    // Full adaptation result with signed offset, clamped to 0..15
    // ****************************************************************
    logic signed [5:0] offs;
    logic signed [5:0] sum;
    logic [3:0] full_adj;
    // Negative sign maps codes 0..7 onto -8..-1
    assign offs = CFG.eq_offset_sign ? {3'b111, CFG.eq_offset_value}
                                     : {3'b000, CFG.eq_offset_value};
    assign sum = $signed({2'b00, MEAS.full_eq}) + offs;
    assign full_adj = sum[5] ? 4'h0
                    : (sum > $signed({2'b00, AEQC_EQ_MAX})) ? AEQC_EQ_MAX
                    : sum[3:0];

    // ****************************************************************
    // EQ selection
    // ****************************************************************
    logic [3:0] fast_eq;
    logic [3:0] eq_d;
    assign fast_eq = short_ch ? MEAS.short_eq : LONG_EQ;
    // Offset touches only the full path; fast ignores it
    assign eq_d = !CFG.adapt_enable ? MEAS.short_eq
                : CFG.full_mode ? full_adj
                : fast_eq;

    // Registered EQ and class outputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            EQ <= 4'h0;
            IS_SHORT <= 1'b0;
        end else begin
            EQ <= eq_d;
            IS_SHORT <= short_ch;
        end
    end

endmodule : aeqc_rx_eq
`default_nettype wire

// ==== hdl/aeqc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module aeqc_regs (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire aeqc_pkg::aeqc_rx_meas_s [1:0] RX_MEAS,
    input wire logic ELEC_IDLE,
    output logic ADAPT_ENABLE,
    output logic FULL_MODE,
    output logic FULL_HITS_EVERY_EQ,
    output logic [3:0] FULL_SEARCH_MAX_EQ,
    output logic [1:0][3:0] RX_EQ,
    output logic [1:0] RX_IS_SHORT,
    output logic ENTER_U1,
    output logic ENTER_U3
);
    import aeqc_pkg::*;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] long_eq_q;
    logic [7:0] rdata_q;
    logic u1_q;
    logic u3_q;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic hit_a;
    logic hit_b;
    logic hit_long;
    logic [7:0] rd_mux;
    assign hit_a = aeqc_hit(REG_ADDR, AEQC_ADDR_CTRL_A);
    assign hit_b = aeqc_hit(REG_ADDR, AEQC_ADDR_CTRL_B);
    assign hit_long = aeqc_hit(REG_ADDR, AEQC_ADDR_LONG_EQ);
    assign rd_mux = hit_a ? ctrl_a_q
                  : hit_b ? (ctrl_b_q & AEQC_CTRL_B_MASK)
                  : hit_long ? long_eq_q
                  : AEQC_UNMAPPED_DATA;

    // Register writes; reserved bit of control B never stores
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl_a_q <= AEQC_RST_CTRL_A;
            ctrl_b_q <= AEQC_RST_CTRL_B;
            long_eq_q <= AEQC_RST_LONG_EQ;
        end else if (REG_WR) begin
            if (hit_a) begin
                ctrl_a_q <= REG_WDATA;
            end
            if (hit_b) begin
                ctrl_b_q <= REG_WDATA & AEQC_CTRL_B_MASK;
            end
            if (hit_long) begin
                long_eq_q <= REG_WDATA;
            end
        end
    end

    // Read data captured one cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= 8'h00;
        end else if (REG_RD) begin
            rdata_q <= rd_mux;
        end
    end
    assign REG_RDATA = rdata_q;

    // ****************************************************************
    // Field views
    // ****************************************************************
    aeqc_ctrl_a_s ctrl_a;
    aeqc_ctrl_b_s ctrl_b;
    aeqc_long_eq_s long_eq;
    logic full_sel;
    assign ctrl_a = aeqc_ctrl_a_s'(ctrl_a_q);
    assign ctrl_b = aeqc_ctrl_b_s'(ctrl_b_q);
    assign long_eq = aeqc_long_eq_s'(long_eq_q);
    // Mode bit 0 picks full over fast; codes 0 and 2 are both fast
    assign full_sel = ctrl_a.adapt_mode_sel[0];

    // Control outputs toward the adaptation engine
    assign ADAPT_ENABLE = ctrl_a.adapt_enable;
    assign FULL_MODE = ctrl_a.adapt_enable & full_sel;
    assign FULL_HITS_EVERY_EQ =
        (ctrl_a.adapt_mode_sel == AEQC_MODE_FULL_ALL);
    assign FULL_SEARCH_MAX_EQ = ctrl_a.full_search_max_eq;

    // ****************************************************************
    // Per receiver EQ resolution
    // ****************************************************************
    aeqc_rx_cfg_s rx_cfg;
    logic [1:0][3:0] long_sel;
    assign rx_cfg.adapt_enable = ctrl_a.adapt_enable;
    assign rx_cfg.full_mode = full_sel;
    assign rx_cfg.eq_offset_sign = ctrl_b.eq_offset_sign;
    assign rx_cfg.eq_offset_value = ctrl_b.eq_offset_value;
    assign rx_cfg.limit_mv = 11'({8'h00, ctrl_b.channel_class_threshold}
                                 * AEQC_LIMIT_STEP);
    assign long_sel[0] = long_eq.long_channel_eq_rx_a;
    assign long_sel[1] = long_eq.long_channel_eq_rx_b;

    genvar gi;
    generate
        for (gi = 0; gi < AEQC_NUM_RX; gi++) begin : g_rx
            aeqc_rx_eq u_rx (
                .CLK(CLK),
                .RESET(RESET),
                .CFG(rx_cfg),
                .MEAS(RX_MEAS[gi]),
                .LONG_EQ(long_sel[gi]),
                .EQ(RX_EQ[gi]),
                .IS_SHORT(RX_IS_SHORT[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Low power entry on electrical idle
    // ****************************************************************
    // Registered level requests follow the idle input by one cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            u1_q <= 1'b0;
            u3_q <= 1'b0;
        end else begin
            u1_q <= ELEC_IDLE & ~ctrl_a.idle_enters_u3;
            u3_q <= ELEC_IDLE & ctrl_a.idle_enters_u3;
        end
    end
    assign ENTER_U1 = u1_q;
    assign ENTER_U3 = u3_q;

endmodule : aeqc_regs
`default_nettype wire

// ==== bench/aeqc_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module aeqc_regs_chk (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire aeqc_pkg::aeqc_rx_meas_s [1:0] RX_MEAS,
    input wire logic ELEC_IDLE,
    input wire logic ADAPT_ENABLE,
    input wire logic FULL_MODE,
    input wire logic FULL_HITS_EVERY_EQ,
    input wire logic [3:0] FULL_SEARCH_MAX_EQ,
    input wire logic [1:0][3:0] RX_EQ,
    input wire logic ENTER_U1,
    input wire logic ENTER_U3
);
    import aeqc_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Strobes that touch control A and the long channel register
    wire wr_a = REG_WR && REG_ADDR == AEQC_ADDR_CTRL_A;
    wire wr_l = REG_WR && REG_ADDR == AEQC_ADDR_LONG_EQ;
    wire rd_l = REG_RD && !REG_WR && REG_ADDR == AEQC_ADDR_LONG_EQ;
    chk_enable_write: assert property (wr_a |=>
        ADAPT_ENABLE == $past(REG_WDATA[0])) else $error("enable bad");
    chk_full_mode: assert property (wr_a |=>
        FULL_MODE == &$past(REG_WDATA[1:0])) else $error("full bad");
    chk_hits_mode: assert property (wr_a |=>
        FULL_HITS_EVERY_EQ == ($past(REG_WDATA[2:1]) == 2'h1))
        else $error("hits mode bad");
    chk_max_eq: assert property (wr_a |=>
        FULL_SEARCH_MAX_EQ == $past(REG_WDATA[7:4])) else $error("max bad");
    chk_idle_follow: assert property (!$past(RESET) |->
        (ENTER_U1 || ENTER_U3) == $past(ELEC_IDLE)) else $error("idle bad");
    chk_idle_split: assert property (wr_a ##1 ELEC_IDLE |=>
        ENTER_U3 == $past(REG_WDATA[3], 2) && ENTER_U1 != ENTER_U3)
        else $error("low power state bad");
    chk_disabled_eq: assert property (!ADAPT_ENABLE |=>
        RX_EQ == $past({RX_MEAS[1].short_eq, RX_MEAS[0].short_eq}))
        else $error("disabled eq bad");
    chk_long_readback: assert property (
        wr_l ##1 !REG_WR ##1 rd_l |=>
        REG_RDATA == $past(REG_WDATA, 3)) else $error("readback bad");
endmodule : aeqc_regs_chk
bind aeqc_regs aeqc_regs_chk u_chk (.CLK, .RESET, .REG_ADDR, .REG_WR,
    .REG_RD, .REG_WDATA, .REG_RDATA, .RX_MEAS, .ELEC_IDLE, .ADAPT_ENABLE,
    .FULL_MODE, .FULL_HITS_EVERY_EQ, .FULL_SEARCH_MAX_EQ, .RX_EQ,
    .ENTER_U1, .ENTER_U3);
`default_nettype wire

// ==== bench/adaptive_eq_control_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module adaptive_eq_control_regs_tb;
    import aeqc_pkg::*;
    logic clk, reset, wr, rd, idle, en, full, hits, u1, u3;
    logic [7:0] addr, wdata, rdata, ra, rb, rl;
    logic [3:0] maxeq;
    logic [1:0][3:0] eq;
    logic [1:0] short;
    aeqc_rx_meas_s [1:0] meas, m;
    int fail_count, checks;
    // ********
    // Clock and device
    // ********
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    aeqc_regs dut (.CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .RX_MEAS(meas),
        .ELEC_IDLE(idle), .ADAPT_ENABLE(en), .FULL_MODE(full),
        .FULL_HITS_EVERY_EQ(hits), .FULL_SEARCH_MAX_EQ(maxeq), .RX_EQ(eq),
        .RX_IS_SHORT(short), .ENTER_U1(u1), .ENTER_U3(u3));
    // ********
    // Helpers
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask : rd_reg
    // Expected short flag and applied EQ of one receiver
    function automatic logic [4:0] exp_rx(input aeqc_rx_meas_s x,
                                          input logic [3:0] lng);
        int lim;
        int s;
        lim = int'(rb[5:3]) * 40;
        s = int'(x.full_eq) + int'(rb[2:0]) - (rb[7] ? 8 : 0);
        exp_rx[4] = int'(x.dac_level) <= lim && int'(x.dac_level) >= -lim;
        if (!ra[0]) exp_rx[3:0] = x.short_eq;
        else if (!ra[1]) exp_rx[3:0] = exp_rx[4] ? x.short_eq : lng;
        else exp_rx[3:0] = 4'(s < 0 ? 0 : (s > 15 ? 15 : s));
    endfunction : exp_rx
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // ********
    // Tests
    // ********
    initial begin
        reset = 1'b1;
        {wr, rd, idle, addr, wdata, meas} = '0;
        void'($urandom(32'h815c11b1));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_reg(AEQC_ADDR_CTRL_A, 8'h80);
        rd_reg(AEQC_ADDR_CTRL_B, 8'h10);
        rd_reg(AEQC_ADDR_LONG_EQ, 8'h77);
        check({7'h0, en}, 8'h00);
        wr_reg(8'h1f, 8'hff);
        rd_reg(8'h1f, 8'h00);
        $display("test reset and unmapped done");
        for (int i = 0; i < 200; i++) begin
            ra = 8'($urandom);
            ra[2:1] = i[1:0];
            rb = 8'($urandom);
            rl = 8'($urandom);
            for (int k = 0; k < 2; k++) begin
                m[k] = aeqc_rx_meas_s'(18'($urandom));
                // Limit edge and 1 mV past it
                if (i % 3 != 0) m[k].dac_level =
                    10'(k ? 40 * rb[5:3] + i[2] : -40 * rb[5:3] - i[2]);
            end
            wr_reg(AEQC_ADDR_CTRL_A, ra);
            wr_reg(AEQC_ADDR_CTRL_B, rb);
            wr_reg(AEQC_ADDR_LONG_EQ, rl);
            rd_reg(AEQC_ADDR_LONG_EQ, rl);
            rd_reg(AEQC_ADDR_CTRL_A, ra);
            rd_reg(AEQC_ADDR_CTRL_B, rb & 8'hbf);
            @(posedge clk);
            meas <= m;
            idle <= 1'($urandom);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check({short[0], eq[0]},
                exp_rx(m[0], rl[3:0]));
            check({short[1], eq[1]},
                exp_rx(m[1], rl[7:4]));
            check({u3, u1, hits, full, maxeq}, {idle & ra[3], idle & !ra[3],
                ra[2:1] == 2'h1, &ra[1:0], ra[7:4]});
        end
        $display("test random adaptation done"); // offsets and modes
        report_and_stop();
    end
endmodule : adaptive_eq_control_regs_tb
`default_nettype wire
